// *** rtl/i2cm_pkg.sv ***
// Constants, register map and shared types of the I2C master sequencer.
// Assumes an APB master with 32-bit data and one aligned word per register.
package i2cm_pkg;
   localparam int BAUD_W = 7;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] BAUD_OFS = 8'h08;
   localparam logic [7:0] BUF_OFS = 8'h0c;
   // Control word bits
   localparam int CB_EN = 0;
   localparam int CB_START = 1;
   localparam int CB_RSTART = 2;
   localparam int CB_STOP = 3;
   localparam int CB_ACK = 4;
   localparam int CB_ACK_DATA_VALUE = 5;
   localparam int CB_IE = 6;
   // Status word bits
   localparam int SB_BF = 0;
   localparam int SB_WRITE_COLLISION_FLAG = 1;
   localparam int SB_BCL = 2;
   localparam int SB_EVT = 3;
   localparam int SB_START = 4;
   localparam int SB_STOP = 5;
   localparam int SB_ACKSTAT = 6;
   localparam int SB_BUSY = 7;
   localparam logic [BAUD_W-1:0] BAUD_RST = 7'h04;
   localparam logic [7:0] BUF_RST = 8'h00;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } i2cm_apb_req_s;

   typedef enum logic [4:0] {
      S_IDLE = 5'h00,
      S_ST_CHK = 5'h01,
      S_ST_WAIT = 5'h02,
      S_ST_HOLD = 5'h03,
      S_RS_SCLLO = 5'h04,
      S_RS_SDAREL = 5'h05,
      S_RS_SCLREL = 5'h06,
      S_RS_WAIT = 5'h07,
      S_RS_HOLD = 5'h08,
      S_TX_LO = 5'h09,
      S_TX_HI = 5'h0a,
      S_ACK_LO = 5'h0b,
      S_ACK_HI = 5'h0c,
      S_SP_SDALO = 5'h0d,
      S_SP_SCLREL = 5'h0e,
      S_SP_SDAREL = 5'h0f,
      S_SP_DONE = 5'h10
   } i2cm_state_e;
endpackage : i2cm_pkg

// *** rtl/i2cm_core.sv ***
// I2C master sequencer: start, repeated start, byte transmit, acknowledge,
// stop and multi-master collision handling, with an APB register slave.
// Assumes bus line levels arrive synchronous to i_core_clk.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Acknowledge enable holds SCL low and drives the acknowledge data value on SDA.
// - Acknowledge waits a period, releases SCL, counts while high, then ends idle.
// - Buffer write during acknowledge or stop sets write collision, buffer unchanged.
// - Stop drives SDA low, counts, releases SCL, then SDA a period later.
// - SDA high with SCL high marks stop seen; a period later stop ends.
// - In sleep the port keeps working and wakes the processor when enabled.
// - Reset disables the port and aborts any transfer.
// - Start and stop seen clear on reset or disable; bus free rule follows.
// - With interrupt enabled on a busy bus, a stop raises the event.
// - Released SDA read low with SCL high while sending flags collision, idles.
// - Transmit collision halts, clears buffer full, releases lines, allows writes.
// - Condition collision aborts it, releases lines, clears sequence enables.
// - After collision the lines are watched and a stop sets the event.
// - Buffer write after collision restarts from the first data bit.
// - Either line low when start begins aborts start with collision.
// - Start counts with SDA high; SCL low then is a collision.
// - SDA low during first start count drives SDA early, no collision.
// - Else SDA low at count end, count again, then SCL low.
// - Repeated start checks SDA when SCL high and SCL falling early.
// - Both high at count end: SDA low, count, SCL low unconditionally.
// - Stop collides on SDA low after its count or SCL low early.
module i2cm_core
   import i2cm_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire i2cm_apb_req_s i_apb,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   input wire logic i_sda,
   input wire logic i_scl,
   input wire logic i_sleep,
   output logic o_sda_o,
   output logic o_sda_oe,
   output logic o_scl_o,
   output logic o_scl_oe,
   output logic o_irq,
   output logic o_wake
);
   i2cm_state_e st_q, st_d;
   logic [BAUD_W-1:0] cnt_q, reload_q;
   logic [3:0] bit_q, bit_d;
   logic [7:0] buf_q;
   logic en_q, ie_q, ack_data_value_q, start_q, rs_q, stop_q, ack_q;
   logic bf_q, write_collision_flag_q, bcl_q, evt_q, sseen_q, pseen_q, ackstat_q, txreq_q;
   logic sda_oe_q, scl_oe_q, sda_d, scl_d, pready_q, mon_q;
   logic sda_prev_q, scl_prev_q;
   logic load, tick, bcl_ev, done_ev, pseen_ev, bf_clr, tx_take, ackstat_d;
   logic clr_start, clr_rs, clr_stop, clr_ack;
   logic wr, wr_ctrl, wr_stat, wr_baud, wr_buf, buf_ok, seq_busy;
   logic bus_start, bus_stop;

   assign tick = (cnt_q == '0);
   assign seq_busy = start_q | rs_q | stop_q | ack_q;
   assign wr = i_apb.psel & i_apb.penable & i_apb.pwrite & pready_q;
   assign wr_ctrl = wr && (i_apb.paddr == CTRL_OFS);
   assign wr_stat = wr && (i_apb.paddr == STAT_OFS);
   assign wr_baud = wr && (i_apb.paddr == BAUD_OFS);
   assign wr_buf = wr && (i_apb.paddr == BUF_OFS);
   assign buf_ok = (st_q == S_IDLE) && !bf_q && !seq_busy && en_q;
   assign bus_start = scl_prev_q & i_scl & sda_prev_q & ~i_sda;
   assign bus_stop = scl_prev_q & i_scl & ~sda_prev_q & i_sda;

   // APB slave: one wait-free access phase
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         pready_q <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         pready_q <= i_apb.psel & ~i_apb.penable;
         if (i_apb.psel && !i_apb.penable) begin
            o_pslverr <= 1'b0;
            case (i_apb.paddr)
               CTRL_OFS: o_prdata <= {25'h0, ie_q, ack_data_value_q, ack_q, stop_q, rs_q, start_q, en_q};
               STAT_OFS: o_prdata <= {24'h0, (st_q != S_IDLE), ackstat_q, pseen_q, sseen_q,
                                      evt_q, bcl_q, write_collision_flag_q, bf_q};
               BAUD_OFS: o_prdata <= {25'h0, reload_q};
               BUF_OFS: o_prdata <= {24'h0, buf_q};
               default: begin
                  o_prdata <= 32'h0000_0000;
                  o_pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
   assign o_pready = pready_q;

   // Baud generator: reload on demand, count down to zero and rest there
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         reload_q <= BAUD_RST;
         cnt_q <= '0;
      end else begin
         if (wr_baud) begin
            reload_q <= i_apb.pwdata[BAUD_W-1:0];
         end
         if (load) begin
            cnt_q <= reload_q;
         end else if (!tick) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // Control bits; sequence bits only start from idle, no queueing
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         {en_q, ie_q, ack_data_value_q, start_q, rs_q, stop_q, ack_q} <= 7'h00;
      end else begin
         if (wr_ctrl) begin
            en_q <= i_apb.pwdata[CB_EN];
            ie_q <= i_apb.pwdata[CB_IE];
            ack_data_value_q <= i_apb.pwdata[CB_ACK_DATA_VALUE];
         end
         if (wr_ctrl && st_q == S_IDLE && !seq_busy && !txreq_q && i_apb.pwdata[CB_EN]) begin
            start_q <= i_apb.pwdata[CB_START];
            rs_q <= i_apb.pwdata[CB_RSTART];
            stop_q <= i_apb.pwdata[CB_STOP];
            ack_q <= i_apb.pwdata[CB_ACK];
         end else begin
            if (clr_start || bcl_ev || !en_q) start_q <= 1'b0;
            if (clr_rs || bcl_ev || !en_q) rs_q <= 1'b0;
            if (clr_stop || bcl_ev || !en_q) stop_q <= 1'b0;
            if (clr_ack || bcl_ev || !en_q) ack_q <= 1'b0;
         end
      end
   end

   // Buffer and transmit request
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         buf_q <= BUF_RST;
         bf_q <= 1'b0;
         txreq_q <= 1'b0;
      end else begin
         // only an idle, empty port takes a write
         if (wr_buf && buf_ok) begin
            buf_q <= i_apb.pwdata[7:0];
         end
         if (wr_buf && buf_ok) begin
            bf_q <= 1'b1;
         end else if (bf_clr || bcl_ev || !en_q) begin
            bf_q <= 1'b0;
         end
         if (wr_buf && buf_ok) begin
            txreq_q <= 1'b1;
         end else if (tx_take || bcl_ev || !en_q) begin
            txreq_q <= 1'b0;
         end
      end
   end

   // Status flags: hardware set wins over software clear
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         {write_collision_flag_q, bcl_q, evt_q, sseen_q, pseen_q, ackstat_q, mon_q} <= 7'h00;
         sda_prev_q <= 1'b1;
         scl_prev_q <= 1'b1;
      end else begin
         sda_prev_q <= i_sda;
         scl_prev_q <= i_scl;
         write_collision_flag_q <= (write_collision_flag_q & ~(wr_stat & i_apb.pwdata[SB_WRITE_COLLISION_FLAG])) | (wr_buf & ~buf_ok);
         bcl_q <= (bcl_q & ~(wr_stat & i_apb.pwdata[SB_BCL])) | bcl_ev;
         // stop on busy bus with interrupt on
         evt_q <= (evt_q & ~(wr_stat & i_apb.pwdata[SB_EVT])) | done_ev
                  | (bus_stop & en_q & (mon_q | (ie_q & sseen_q)));
         if (bcl_ev) begin
            mon_q <= 1'b1;
         end else if (bus_stop || !en_q) begin
            mon_q <= 1'b0;
         end
         // disable clears start and stop seen
         if (!en_q) begin
            sseen_q <= 1'b0;
            pseen_q <= 1'b0;
         end else if (bus_start) begin
            sseen_q <= 1'b1;
            pseen_q <= 1'b0;
         end else if (bus_stop || pseen_ev) begin
            sseen_q <= 1'b0;
            pseen_q <= 1'b1;
         end
         if (st_q == S_TX_HI && st_d == S_IDLE && !bcl_ev) begin
            ackstat_q <= ackstat_d;
         end
      end
   end

   // event wakes a sleeping core when enabled
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_irq <= 1'b0;
         o_wake <= 1'b0;
      end else begin
         o_irq <= evt_q & ie_q;
         o_wake <= evt_q & ie_q & i_sleep;
      end
   end

   // Sequencer next state
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sda_d = sda_oe_q;
      scl_d = scl_oe_q;
      load = 1'b0;
      bcl_ev = 1'b0;
      done_ev = 1'b0;
      pseen_ev = 1'b0;
      bf_clr = 1'b0;
      tx_take = 1'b0;
      ackstat_d = i_sda;
      {clr_start, clr_rs, clr_stop, clr_ack} = 4'h0;
      case (st_q)
         S_IDLE: begin
            if (start_q) begin
               st_d = S_ST_CHK;
            end else if (rs_q) begin
               scl_d = 1'b1;
               st_d = S_RS_SCLLO;
            end else if (stop_q) begin
               sda_d = 1'b1;
               load = 1'b1;
               st_d = S_SP_SDALO;
            end else if (ack_q) begin
               // SCL low, data value on SDA
               scl_d = 1'b1;
               sda_d = ~ack_data_value_q;
               load = 1'b1;
               st_d = S_ACK_LO;
            end else if (txreq_q) begin
               // every transfer starts at bit 7
               tx_take = 1'b1;
               bit_d = 4'h0;
               scl_d = 1'b1;
               sda_d = ~buf_q[7];
               load = 1'b1;
               st_d = S_TX_LO;
            end
         end
         S_ST_CHK: begin
            if (!i_sda || !i_scl) begin
               bcl_ev = 1'b1;
            end else begin
               load = 1'b1;
               st_d = S_ST_WAIT;
            end
         end
         S_ST_WAIT: begin
            if (!i_sda) begin
               sda_d = 1'b1;
               load = 1'b1;
               st_d = S_ST_HOLD;
            end else if (!i_scl) begin
               bcl_ev = 1'b1;
            end else if (tick) begin
               sda_d = 1'b1;
               load = 1'b1;
               st_d = S_ST_HOLD;
            end
         end
         S_ST_HOLD: begin
            if (tick) begin
               scl_d = 1'b1;
               clr_start = 1'b1;
               done_ev = 1'b1;
               st_d = S_IDLE;
            end
         end
         S_RS_SCLLO: begin
            if (!i_scl) begin
               sda_d = 1'b0;
               load = 1'b1;
               st_d = S_RS_SDAREL;
            end
         end
         S_RS_SDAREL: begin
            if (tick) begin
               scl_d = 1'b0;
               st_d = S_RS_SCLREL;
            end
         end
         S_RS_SCLREL: begin
            if (i_scl) begin
               if (!i_sda) begin
                  bcl_ev = 1'b1;
               end else begin
                  load = 1'b1;
                  st_d = S_RS_WAIT;
               end
            end
         end
         S_RS_WAIT: begin
            if (!i_sda) begin
               sda_d = 1'b1;
               load = 1'b1;
               st_d = S_RS_HOLD;
            end else if (!i_scl) begin
               bcl_ev = 1'b1;
            end else if (tick) begin
               sda_d = 1'b1;
               load = 1'b1;
               st_d = S_RS_HOLD;
            end
         end
         S_RS_HOLD: begin
            if (tick) begin
               scl_d = 1'b1;
               clr_rs = 1'b1;
               done_ev = 1'b1;
               st_d = S_IDLE;
            end
         end
         S_TX_LO: begin
            if (tick) begin
               scl_d = 1'b0;
               load = 1'b1;
               st_d = S_TX_HI;
            end
         end
         S_TX_HI: begin
            // Count restarts while a slave stretches SCL
            if (!i_scl) begin
               load = 1'b1;
            end else if (bit_q != 4'h8 && !sda_oe_q && !i_sda) begin
               bcl_ev = 1'b1;
            end else if (tick) begin
               scl_d = 1'b1;
               load = 1'b1;
               if (bit_q == 4'h8) begin
                  sda_d = 1'b0;
                  bf_clr = 1'b1;
                  done_ev = 1'b1;
                  st_d = S_IDLE;
               end else begin
                  bit_d = bit_q + 4'h1;
                  sda_d = (bit_q == 4'h7) ? 1'b0 : ~buf_q[3'(4'h6 - bit_q)];
                  st_d = S_TX_LO;
               end
            end
         end
         S_ACK_LO: begin
            if (tick) begin
               scl_d = 1'b0;
               load = 1'b1;
               st_d = S_ACK_HI;
            end
         end
         S_ACK_HI: begin
            if (!i_scl) begin
               load = 1'b1;
            end else if (!sda_oe_q && !i_sda) begin
               bcl_ev = 1'b1;
            end else if (tick) begin
               scl_d = 1'b1;
               clr_ack = 1'b1;
               st_d = S_IDLE;
            end
         end
         S_SP_SDALO: begin
            // count only once SDA reads low
            if (i_sda) begin
               load = 1'b1;
            end else if (tick) begin
               scl_d = 1'b0;
               load = 1'b1;
               st_d = S_SP_SCLREL;
            end
         end
         S_SP_SCLREL: begin
            if (!i_scl) begin
               load = 1'b1;
            end else if (tick) begin
               sda_d = 1'b0;
               load = 1'b1;
               st_d = S_SP_SDAREL;
            end
         end
         S_SP_SDAREL: begin
            if (i_sda && i_scl) begin
               pseen_ev = 1'b1;
               load = 1'b1;
               st_d = S_SP_DONE;
            // SCL low or SDA held low
            end else if (!i_scl || tick) begin
               bcl_ev = 1'b1;
            end
         end
         S_SP_DONE: begin
            if (tick) begin
               clr_stop = 1'b1;
               done_ev = 1'b1;
               st_d = S_IDLE;
            end
         end
         default: st_d = S_IDLE;
      endcase
      if (bcl_ev || !en_q) begin
         st_d = S_IDLE;
         sda_d = 1'b0;
         scl_d = 1'b0;
      end
   end

   // Sequencer state and line drivers
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_q <= S_IDLE;
         bit_q <= 4'h0;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         sda_oe_q <= sda_d;
         scl_oe_q <= scl_d;
      end
   end
   assign o_sda_oe = sda_oe_q;
   assign o_scl_oe = scl_oe_q;
   assign o_sda_o = 1'b0;
   assign o_scl_o = 1'b0;

   write_collision_flag_set_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (wr_buf && (ack_q || stop_q)) |=> write_collision_flag_q && $stable(buf_q))
      else $error("write during sequence not rejected");
   ack_drive_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (st_q == S_ACK_LO) |-> o_scl_oe && (o_sda_oe == !ack_data_value_q))
      else $error("acknowledge lines wrong");
   bcl_idle_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      bcl_ev |=> st_q == S_IDLE && !o_sda_oe && !o_scl_oe && bcl_q)
      else $error("collision did not idle");
   bcl_bf_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      bcl_ev |=> !bf_q && !txreq_q)
      else $error("collision kept buffer full");
   bcl_seq_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      bcl_ev |=> !seq_busy)
      else $error("collision kept sequence enable");
   rst_idle_a: assert property (@(posedge i_core_clk)
      i_srst |=> st_q == S_IDLE && !o_scl_oe && !o_sda_oe && !en_q)
      else $error("reset did not abort");
   dis_seen_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      !en_q |=> !sseen_q && !pseen_q)
      else $error("seen flags kept while disabled");
   start_abort_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (st_q == S_ST_CHK && en_q && (!i_sda || !i_scl)) |=> bcl_q && st_q == S_IDLE)
      else $error("start on busy lines not aborted");
   ack_end_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (st_q == S_ACK_HI && st_d == S_IDLE && !bcl_ev && en_q) |=> !ack_q && o_scl_oe)
      else $error("acknowledge end wrong");
   stop_done_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (st_q == S_SP_DONE && tick && en_q) |=> evt_q && !stop_q && pseen_q)
      else $error("stop end wrong");
endmodule : i2cm_core

// *** verif/i2cm_bus_peer.sv ***
// Model of the other parties on the shared I2C lines: pull-ups plus one
// peer that holds either line low when the bench asks.
// Assumes open-drain enables from the core, synchronous to i_core_clk.
`timescale 1ns/1ps
module i2cm_bus_peer (
   input wire logic i_core_clk,
   input wire logic i_sda_oe,
   input wire logic i_scl_oe,
   input wire logic i_hold_sda,
   input wire logic i_hold_scl,
   output logic o_sda,
   output logic o_scl
);
   logic hold_sda_q;
   logic hold_scl_q;
   always_ff @(posedge i_core_clk) begin
      hold_sda_q <= i_hold_sda;
      hold_scl_q <= i_hold_scl;
   end
   // Released lines float high, never hold a stale level
   assign o_sda = !(i_sda_oe || hold_sda_q);
   assign o_scl = !(i_scl_oe || hold_scl_q);
endmodule : i2cm_bus_peer

// *** verif/tb_i2c_master_ack_stop_arbitration.sv ***
// Self-checking bench for the I2C master sequencer: APB register tasks
// and directed bus sequences through the peer model.
// Assumes the package and the peer model are compiled first.
`timescale 1ns/1ps
module tb_i2c_master_ack_stop_arbitration
   import i2cm_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sleep = 1'b0;
   logic hold_sda = 1'b0;
   logic hold_scl = 1'b0;
   i2cm_apb_req_s req = '0;
   logic pready, pslverr, sda, scl, sda_o, scl_o, sda_oe, scl_oe, irq, wake, err;
   logic [31:0] prdata, rd;
   int failures = 0;
   int cmp_count = 0;
   int cyc = 0;

   initial forever #12.5 clk = ~clk;

   i2cm_core DUT (.i_core_clk(clk), .i_srst(srst), .i_apb(req), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_sda(sda), .i_scl(scl), .i_sleep(sleep),
      .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_scl_o(scl_o), .o_scl_oe(scl_oe),
      .o_irq(irq), .o_wake(wake));

   i2cm_bus_peer peer (.i_core_clk(clk), .i_sda_oe(sda_oe), .i_scl_oe(scl_oe),
      .i_hold_sda(hold_sda), .i_hold_scl(hold_scl), .o_sda(sda), .o_scl(scl));

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         $display("ERROR at %0t: timeout after %0d cycles", $time, cyc);
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] bt(input int b);
      return 32'h1 << b;
   endfunction : bt

   // Request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic poll(input logic [7:0] a, input int b, input logic v);
      apb(1'b0, a, 32'h0);
      for (int n = 0; n < 300 && rd[b] !== v; n++) apb(1'b0, a, 32'h0);
      chk(32'(rd[b]), 32'(v));
   endtask : poll

   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, BAUD_OFS, 32'h0);
      chk(rd, 32'(BAUD_RST));
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'(rd[7:0]), 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      // Peer stretches SCL so the acknowledge must wait for it
      for (int v = 0; v < 2; v++) begin
         hold_scl <= 1'b1;
         apb(1'b1, CTRL_OFS, bt(CB_EN) | bt(CB_ACK) | (32'(v) << CB_ACK_DATA_VALUE));
         repeat (3) @(negedge clk);
         chk(32'({sda_oe, scl_oe}), 32'({v == 0, 1'b1}));
         apb(1'b1, BUF_OFS, 32'h5a);
         repeat (30) @(negedge clk);
         apb(1'b0, CTRL_OFS, 32'h0);
         chk(32'(rd[CB_ACK]), 32'h1);
         hold_scl <= 1'b0;
         poll(CTRL_OFS, CB_ACK, 1'b0);
         chk(32'(scl_oe), 32'h1);
         apb(1'b0, STAT_OFS, 32'h0);
         chk(32'(rd[3:0]), 32'h2);
         apb(1'b1, STAT_OFS, bt(SB_WRITE_COLLISION_FLAG));
      end
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'(rd[3:0]), 32'h0);
      apb(1'b1, CTRL_OFS, bt(CB_EN) | bt(CB_STOP));
      repeat (2) @(negedge clk);
      chk(32'(sda_oe), 32'h1);
      apb(1'b1, BUF_OFS, 32'h33);
      poll(CTRL_OFS, CB_STOP, 1'b0);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'(rd[5:0]), 32'h2a);
      chk(32'({sda_oe, scl_oe}), 32'h0);
      apb(1'b1, CTRL_OFS, bt(CB_EN) | bt(CB_IE));
      sleep <= 1'b1;
      repeat (3) @(negedge clk);
      chk(32'({irq, wake}), 32'h3);
      apb(1'b1, STAT_OFS, 32'h0e);
      repeat (3) @(negedge clk);
      chk(32'({irq, wake}), 32'h0);
      // Another master's start and stop while the interrupt is on
      @(posedge clk);
      hold_sda <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'(rd[SB_START]), 32'h1);
      hold_sda <= 1'b0;
      poll(STAT_OFS, SB_EVT, 1'b1);
      apb(1'b1, STAT_OFS, 32'h0e);
      apb(1'b1, CTRL_OFS, 32'h0);
      sleep <= 1'b0;
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'(rd[5:4]), 32'h0);
      // Start while the peer already holds SDA low
      hold_sda <= 1'b1;
      apb(1'b1, CTRL_OFS, bt(CB_EN) | bt(CB_START));
      poll(CTRL_OFS, CB_START, 1'b0);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'(rd[SB_BCL]), 32'h1);
      chk(32'({sda_oe, scl_oe}), 32'h0);
      hold_sda <= 1'b0;
      poll(STAT_OFS, SB_EVT, 1'b1);
      apb(1'b1, STAT_OFS, 32'h0e);
      apb(1'b1, CTRL_OFS, bt(CB_EN) | bt(CB_START));
      poll(CTRL_OFS, CB_START, 1'b0);
      chk(32'({sda_oe, scl_oe}), 32'h3);
      apb(1'b1, STAT_OFS, 32'h0e);
      apb(1'b1, BUF_OFS, 32'hff);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'(rd[SB_BF]), 32'h1);
      // Collide a few bits into the byte, not on its first bit
      repeat (30) @(posedge clk);
      hold_sda <= 1'b1;
      poll(STAT_OFS, SB_BCL, 1'b1);
      chk(32'(rd[SB_BF]), 32'h0);
      chk(32'({sda_oe, scl_oe}), 32'h0);
      hold_sda <= 1'b0;
      poll(STAT_OFS, SB_EVT, 1'b1);
      apb(1'b1, STAT_OFS, 32'h0e);
      apb(1'b1, BUF_OFS, 32'h7f);
      for (int n = 0; n < 80 && sda_oe !== 1'b1; n++) @(negedge clk);
      chk(32'(sda_oe), 32'h1);
      poll(STAT_OFS, SB_EVT, 1'b1);
      chk(32'(rd[SB_ACKSTAT]), 32'h1);
      // Repeated start from the held-low clock left by the byte
      apb(1'b1, STAT_OFS, 32'h0e);
      apb(1'b1, CTRL_OFS, bt(CB_EN) | bt(CB_RSTART));
      poll(CTRL_OFS, CB_RSTART, 1'b0);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'(rd[3:0]), 32'h8);
      chk(32'({sda_oe, scl_oe}), 32'h3);
      apb(1'b1, STAT_OFS, 32'h0e);
      apb(1'b1, CTRL_OFS, bt(CB_EN) | bt(CB_STOP));
      poll(CTRL_OFS, CB_STOP, 1'b0);
      chk(32'({sda_oe, scl_oe}), 32'h0);
      // Peer pulls SDA one edge into the first start count
      apb(1'b1, CTRL_OFS, bt(CB_EN) | bt(CB_START));
      @(posedge clk);
      hold_sda <= 1'b1;
      poll(CTRL_OFS, CB_START, 1'b0);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(32'(rd[SB_BCL]), 32'h0);
      chk(32'({sda_oe, scl_oe}), 32'h3);
      hold_sda <= 1'b0;
      // Reset in mid-byte
      apb(1'b1, BUF_OFS, 32'h00);
      repeat (12) @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk(32'({sda_oe, scl_oe, sda_o, scl_o, irq, wake}), 32'h0);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(rd, 32'h0);
      complete_run();
   end
endmodule : tb_i2c_master_ack_stop_arbitration
